// *** logic/charger_event_fault_interrupt_flags.sv ***
// Event and fault flag registers with masked interrupt pulse
`timescale 1ns/1ps
`default_nettype none
`include "chg_irq_defines.svh"
// Overview of operation
// - Fault flag register clears itself after the host reads it.
// - Event flag register clears itself after the host reads it.
// - Power-good toggle either way sets event bit 7.
// - Rising current, voltage, thermal regulation set event bits 6,5,4.
// - Rising watchdog-expired status sets event bit 3.
// - Rising termination indication sets event bit 2.
// - Any change of the charge state field sets event bit 0.
// - Reserved event bit 1 and fault bit 0 always read zero.
// - Rising input, thermal, battery overvoltage set fault bits 7,6,5.
// - Rising flying capacitor fault sets fault bit 4.
// - Rising safety timer expiry sets fault bit 3.
// - Rising precondition and weak source failures set fault bits 2,1.
// - Event mask 0 lets a pulse out, 1 suppresses it.
// - Fault mask 0 lets a pulse out, 1 suppresses it.
// - Both masks read/write and reset to zero.
// - Four fault statuses held cleared while watchdog expired.
// - Preset bit restores defaults, restarts safety timer, self-clears.
module charger_event_fault_interrupt_flags #(
    parameter int PULSE_NS = `IRQ_PULSE_NS
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire chg_irq_pkg::status_type STATUS,
    input wire chg_irq_pkg::reg_req_type REQ,
    output logic [7:0] RDATA,
    output logic IRQ_PULSE,
    output logic PRESET_PULSE,
    output logic SAFETY_TIMER_RESTART
);
    localparam int PULSE_CYC_RAW = PULSE_NS / `CLK_PERIOD_NS;
    localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
    localparam int PCW = $clog2(PULSE_CYC + 1);

    // Refuse a pulse width the counter cannot serve
    if (PULSE_NS < 1) begin
        $error("pulse width must be positive");
    end

    logic [7:0] event_hit, fault_hit;
    logic wd_hold;
    logic [3:0] fault_gated;
    logic [7:0] event_flags_reg, event_flags_next;
    logic [7:0] fault_flags_reg, fault_flags_next;
    logic [7:0] event_mask_reg, event_mask_next;
    logic [7:0] fault_mask_reg, fault_mask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic preset_reg, preset_next;
    logic [PCW-1:0] pulse_cnt_reg, pulse_cnt_next;
    logic irq_reg, irq_next;
    logic wd_s1_reg, wd_s2_reg, wd_s3_reg;
    logic wd_s1_next, wd_s2_next, wd_s3_next;
    logic preset_req;
    logic [7:0] event_raise, fault_raise;

    // Watchdog level, released once second and third stages agree low
    always_comb begin
        wd_s1_next = STATUS.watchdog_expired_status;
        wd_s2_next = wd_s1_reg;
        wd_s3_next = wd_s2_reg;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wd_s1_reg <= 1'b0;
            wd_s2_reg <= 1'b0;
            wd_s3_reg <= 1'b0;
        end else begin
            wd_s1_reg <= wd_s1_next;
            wd_s2_reg <= wd_s2_next;
            wd_s3_reg <= wd_s3_next;
        end
    end

    // Statuses forced low while the watchdog has expired
    always_comb begin
        wd_hold = STATUS.watchdog_expired_status | wd_s2_reg | wd_s3_reg;
        fault_gated[3] = STATUS.input_overvoltage & ~wd_hold;
        fault_gated[2] = STATUS.thermal_shutdown & ~wd_hold;
        fault_gated[1] = STATUS.battery_overvoltage & ~wd_hold;
        fault_gated[0] = STATUS.flying_cap_fault & ~wd_hold;
    end

    // Event detectors
    edge_catch #(.WIDTH(1), .ANY_CHANGE(1'b1)) u_pg (
        .clk(CLK), .rst_n(RST_N), .din(STATUS.power_good),
        .hit(event_hit[`POWER_GOOD_BIT]));
    edge_catch #(.WIDTH(1)) u_icr (
        .clk(CLK), .rst_n(RST_N), .din(STATUS.input_current_regulation),
        .hit(event_hit[`INPUT_CURRENT_REG_BIT]));
    edge_catch #(.WIDTH(1)) u_ivr (
        .clk(CLK), .rst_n(RST_N), .din(STATUS.input_voltage_regulation),
        .hit(event_hit[`INPUT_VOLTAGE_REG_BIT]));
    edge_catch #(.WIDTH(1)) u_tr (
        .clk(CLK), .rst_n(RST_N), .din(STATUS.thermal_regulation),
        .hit(event_hit[`THERMAL_REG_BIT]));
    edge_catch #(.WIDTH(1)) u_wd (
        .clk(CLK), .rst_n(RST_N), .din(STATUS.watchdog_expired_status),
        .hit(event_hit[`WATCHDOG_BIT]));
    edge_catch #(.WIDTH(1)) u_term (
        .clk(CLK), .rst_n(RST_N), .din(STATUS.termination),
        .hit(event_hit[`TERMINATION_BIT]));
    edge_catch #(.WIDTH(3), .ANY_CHANGE(1'b1)) u_chs (
        .clk(CLK), .rst_n(RST_N), .din(STATUS.charge_state_field),
        .hit(event_hit[`CHARGE_STATE_BIT]));
    assign event_hit[1] = 1'b0;

    // Fault detectors
    edge_catch #(.WIDTH(1)) u_iov (
        .clk(CLK), .rst_n(RST_N), .din(fault_gated[3]),
        .hit(fault_hit[`INPUT_OVERVOLTAGE_BIT]));
    edge_catch #(.WIDTH(1)) u_tsd (
        .clk(CLK), .rst_n(RST_N), .din(fault_gated[2]),
        .hit(fault_hit[`THERMAL_SHUTDOWN_BIT]));
    edge_catch #(.WIDTH(1)) u_bov (
        .clk(CLK), .rst_n(RST_N), .din(fault_gated[1]),
        .hit(fault_hit[`BATTERY_OVERVOLTAGE_BIT]));
    edge_catch #(.WIDTH(1)) u_fly (
        .clk(CLK), .rst_n(RST_N), .din(fault_gated[0]),
        .hit(fault_hit[`FLYING_CAP_BIT]));
    edge_catch #(.WIDTH(1)) u_tmr (
        .clk(CLK), .rst_n(RST_N), .din(STATUS.safety_timer_expired),
        .hit(fault_hit[`SAFETY_TIMER_BIT]));
    edge_catch #(.WIDTH(1)) u_cap (
        .clk(CLK), .rst_n(RST_N), .din(STATUS.cap_precondition_status),
        .hit(fault_hit[`CAP_PRECONDITION_BIT]));
    edge_catch #(.WIDTH(1)) u_weak (
        .clk(CLK), .rst_n(RST_N), .din(STATUS.weak_source_status),
        .hit(fault_hit[`WEAK_SOURCE_BIT]));
    assign fault_hit[0] = 1'b0;

    // Flag and mask next values; set beats clear-on-read
    always_comb begin
        preset_req = REQ.wr && (REQ.addr == `PRESET_ADDR)
            && REQ.wdata[`PRESET_BIT];
        event_raise = event_hit & `EVENT_VALID_MASK;
        fault_raise = fault_hit & `FAULT_VALID_MASK;
        event_flags_next = event_flags_reg;
        fault_flags_next = fault_flags_reg;
        event_mask_next = event_mask_reg;
        fault_mask_next = fault_mask_reg;
        if (REQ.rd && REQ.addr == `EVENT_FLAGS_ADDR)
            event_flags_next = `FLAG_RESET;
        if (REQ.rd && REQ.addr == `FAULT_FLAGS_ADDR)
            fault_flags_next = `FLAG_RESET;
        if (REQ.wr && REQ.addr == `EVENT_MASK_ADDR)
            event_mask_next = REQ.wdata & `EVENT_VALID_MASK;
        if (REQ.wr && REQ.addr == `FAULT_MASK_ADDR)
            fault_mask_next = REQ.wdata & `FAULT_VALID_MASK;
        event_flags_next = event_flags_next | event_raise;
        fault_flags_next = fault_flags_next | fault_raise;
        if (preset_reg) begin
            event_flags_next = `FLAG_RESET;
            fault_flags_next = `FLAG_RESET;
            event_mask_next = `MASK_RESET;
            fault_mask_next = `MASK_RESET;
        end
        preset_next = preset_req;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            event_flags_reg <= `FLAG_RESET;
            fault_flags_reg <= `FLAG_RESET;
            event_mask_reg <= `MASK_RESET;
            fault_mask_reg <= `MASK_RESET;
            preset_reg <= 1'b0;
        end else begin
            event_flags_reg <= event_flags_next;
            fault_flags_reg <= fault_flags_next;
            event_mask_reg <= event_mask_next;
            fault_mask_reg <= fault_mask_next;
            preset_reg <= preset_next;
        end
    end

    // Read data, registered one cycle after the read
    always_comb begin
        rdata_next = 8'h00;
        if (REQ.rd) begin
            unique case (REQ.addr)
                `EVENT_FLAGS_ADDR: rdata_next = event_flags_reg;
                `FAULT_FLAGS_ADDR: rdata_next = fault_flags_reg;
                `EVENT_MASK_ADDR: rdata_next = event_mask_reg;
                `FAULT_MASK_ADDR: rdata_next = fault_mask_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Interrupt pulse of fixed width from unmasked sources
    always_comb begin
        pulse_cnt_next = pulse_cnt_reg;
        irq_next = irq_reg;
        if ((|(event_raise & ~event_mask_reg))
            || (|(fault_raise & ~fault_mask_reg))) begin
            pulse_cnt_next = PCW'(PULSE_CYC - 1);
            irq_next = 1'b1;
        end else if (pulse_cnt_reg != '0) begin
            pulse_cnt_next = pulse_cnt_reg - 1'b1;
        end else begin
            irq_next = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= 8'h00;
            pulse_cnt_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            pulse_cnt_reg <= pulse_cnt_next;
            irq_reg <= irq_next;
        end
    end

    assign RDATA = rdata_reg;
    assign IRQ_PULSE = irq_reg;
    assign PRESET_PULSE = preset_reg;
    assign SAFETY_TIMER_RESTART = preset_reg;

    // Flag clear and set checks
    chk_event_clear: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (REQ.rd && REQ.addr == `EVENT_FLAGS_ADDR && event_raise == 8'h00
         && !preset_reg) |=> event_flags_reg == 8'h00)
        else $error("event flags not cleared by read");
    chk_fault_clear: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (REQ.rd && REQ.addr == `FAULT_FLAGS_ADDR && fault_raise == 8'h00
         && !preset_reg) |=> fault_flags_reg == 8'h00)
        else $error("fault flags not cleared by read");
    chk_reserved_zero: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !event_flags_reg[1] && !fault_flags_reg[0]
        && !event_mask_reg[1] && !fault_mask_reg[0])
        else $error("reserved bit set");
    chk_pg_toggle: assert property (
        @(posedge CLK) disable iff (!RST_N)
        $changed(STATUS.power_good) ##2 !preset_reg
        |=> event_flags_reg[`POWER_GOOD_BIT])
        else $error("power good toggle missed");
    chk_charge_change: assert property (
        @(posedge CLK) disable iff (!RST_N)
        $changed(STATUS.charge_state_field) ##2 !preset_reg
        |=> event_flags_reg[`CHARGE_STATE_BIT])
        else $error("charge state change missed");
    chk_event_set: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (event_raise != 8'h00 && !preset_reg)
        |=> (event_flags_reg & $past(event_raise)) == $past(event_raise))
        else $error("event flag not set");
    chk_fault_set: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (fault_raise != 8'h00 && !preset_reg)
        |=> (fault_flags_reg & $past(fault_raise)) == $past(fault_raise))
        else $error("fault flag not set");
    chk_wd_hold: assert property (
        @(posedge CLK) disable iff (!RST_N)
        $past(wd_hold, 2) |-> fault_hit[7:4] == 4'h0)
        else $error("fault status not held under watchdog");

    // Interrupt pulse checks
    chk_masked_quiet: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (!irq_reg && (event_raise & ~event_mask_reg) == 8'h00
         && (fault_raise & ~fault_mask_reg) == 8'h00) |=> !irq_reg)
        else $error("pulse from masked source");
    chk_event_pulse: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (|(event_raise & ~event_mask_reg)) |=> irq_reg)
        else $error("unmasked event gave no pulse");
    chk_pulse_out: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (|(fault_raise & ~fault_mask_reg)) |=> irq_reg)
        else $error("unmasked fault gave no pulse");

    // Register access and preset checks
    chk_read_data: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (REQ.rd && REQ.addr == `EVENT_FLAGS_ADDR)
        |=> RDATA == $past(event_flags_reg))
        else $error("event flag read returned wrong data");
    chk_event_mask_write: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (REQ.wr && REQ.addr == `EVENT_MASK_ADDR && !preset_reg)
        |=> event_mask_reg == ($past(REQ.wdata) & `EVENT_VALID_MASK))
        else $error("event mask write lost");
    chk_fault_mask_write: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (REQ.wr && REQ.addr == `FAULT_MASK_ADDR && !preset_reg)
        |=> fault_mask_reg == ($past(REQ.wdata) & `FAULT_VALID_MASK))
        else $error("fault mask write lost");
    chk_preset_clear: assert property (
        @(posedge CLK) disable iff (!RST_N)
        preset_req |=> preset_reg ##1 (event_mask_reg == 8'h00
        && fault_mask_reg == 8'h00 && !preset_reg))
        else $error("preset did not restore defaults");
    chk_preset_once: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (preset_reg && !preset_req) |=> !preset_reg)
        else $error("preset bit did not clear itself");

    // Scenario covers
    cov_event_pulse: cover property (@(posedge CLK) disable iff (!RST_N)
        (|(event_raise & ~event_mask_reg)) ##1 irq_reg);
    cov_masked_flag: cover property (@(posedge CLK) disable iff (!RST_N)
        (|(event_raise & event_mask_reg)) ##1 !irq_reg);
    cov_wd_hold: cover property (@(posedge CLK) disable iff (!RST_N)
        wd_hold && STATUS.input_overvoltage);
    cov_preset: cover property (@(posedge CLK) disable iff (!RST_N)
        preset_req);
endmodule
`default_nettype wire

// *** logic/chg_irq_defines.svh ***
// Offsets, field positions, reset values and timing values in ns of the flag block
`ifndef CHG_IRQ_DEFINES_SVH
`define CHG_IRQ_DEFINES_SVH

`define EVENT_FLAGS_ADDR 4'h9
`define FAULT_FLAGS_ADDR 4'ha
`define EVENT_MASK_ADDR 4'hb
`define FAULT_MASK_ADDR 4'hc
`define PRESET_ADDR 4'hd
`define PRESET_BIT 7
`define POWER_GOOD_BIT 7
`define INPUT_CURRENT_REG_BIT 6
`define INPUT_VOLTAGE_REG_BIT 5
`define THERMAL_REG_BIT 4
`define WATCHDOG_BIT 3
`define TERMINATION_BIT 2
`define CHARGE_STATE_BIT 0
`define INPUT_OVERVOLTAGE_BIT 7
`define THERMAL_SHUTDOWN_BIT 6
`define BATTERY_OVERVOLTAGE_BIT 5
`define FLYING_CAP_BIT 4
`define SAFETY_TIMER_BIT 3
`define CAP_PRECONDITION_BIT 2
`define WEAK_SOURCE_BIT 1
`define EVENT_VALID_MASK 8'hfd
`define FAULT_VALID_MASK 8'hfe
`define FLAG_RESET 8'h00
`define MASK_RESET 8'h00
`define IRQ_PULSE_NS 100
`define CLK_PERIOD_NS 10

`endif

// *** logic/chg_irq_pkg.sv ***
// Types shared by the flag block
package chg_irq_pkg;
    // Raw status inputs watched by the detectors
    typedef struct packed {
        logic power_good;
        logic input_current_regulation;
        logic input_voltage_regulation;
        logic thermal_regulation;
        logic watchdog_expired_status;
        logic termination;
        logic [2:0] charge_state_field;
        logic input_overvoltage;
        logic thermal_shutdown;
        logic battery_overvoltage;
        logic flying_cap_fault;
        logic safety_timer_expired;
        logic cap_precondition_status;
        logic weak_source_status;
    } status_type;

    // Register access from the serial management engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_type;
endpackage

// *** logic/edge_catch.sv ***
// Synchroniser and rising or change detector for one status signal
`timescale 1ns/1ps
`default_nettype none
module edge_catch #(
    parameter int WIDTH = 1,
    parameter bit ANY_CHANGE = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic hit
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg;
    logic [WIDTH-1:0] s1_next, s2_next, s3_next;

    // Refuse a width the detector cannot serve
    if (WIDTH < 1) begin
        $error("edge_catch width must be at least 1");
    end

    // Three stage pipeline, first stage read only by the second
    always_comb begin
        s1_next = din;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    // Any change (ANY_CHANGE set) or a rise of bit 0 (ANY_CHANGE clear), seen once second and third stages disagree
    always_comb begin
        if (ANY_CHANGE)
            hit = (s2_reg != s3_reg);
        else
            hit = s2_reg[0] & ~s3_reg[0];
    end
endmodule
`default_nettype wire

// *** testbench/host_model.sv ***
// Host processor model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    output var chg_irq_pkg::reg_req_type req,
    input wire logic [7:0] rdata
);
    initial req = '0;

    // One-cycle write strobe, taken by the device at the next edge
    task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
        @(posedge clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(posedge clk);
        req <= '0;
    endtask

    // Register reads; a read of a flag register clears what it reports
    task automatic reg_read(input logic [3:0] addr, output logic [7:0] data);
        @(posedge clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        data = rdata;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the event and fault flag block
`timescale 1ns/1ps
`default_nettype none
`include "chg_irq_defines.svh"
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
    num_errors++; $display("Error %s expected %h seen %h", what, exp, got); \
    end end
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    chg_irq_pkg::status_type status = '0;
    chg_irq_pkg::reg_req_type req;
    logic [7:0] rdata;
    logic irq_pulse;
    logic preset_pulse;
    logic timer_restart;
    int num_errors = 0;
    int compares = 0;
    logic [7:0] bit_tab [14] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
        8'h01, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02};
    logic [7:0] d;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    charger_event_fault_interrupt_flags #(.PULSE_NS(100)) dut_u (
        .CLK(clk), .RST_N(rst_n), .STATUS(status), .REQ(req),
        .RDATA(rdata), .IRQ_PULSE(irq_pulse), .PRESET_PULSE(preset_pulse),
        .SAFETY_TIMER_RESTART(timer_restart));

    host_model host_u (.clk(clk), .req(req), .rdata(rdata));

    // Drive one status source; the charge state moves to a new value
    task automatic set_src(input int i, input logic v);
        @(posedge clk);
        case (i)
            0: status.power_good <= v;
            1: status.input_current_regulation <= v;
            2: status.input_voltage_regulation <= v;
            3: status.thermal_regulation <= v;
            4: status.watchdog_expired_status <= v;
            5: status.termination <= v;
            6: status.charge_state_field <= v ? 3'h3 : 3'h4;
            7: status.input_overvoltage <= v;
            8: status.thermal_shutdown <= v;
            9: status.battery_overvoltage <= v;
            10: status.flying_cap_fault <= v;
            11: status.safety_timer_expired <= v;
            12: status.cap_precondition_status <= v;
            default: status.weak_source_status <= v;
        endcase
    endtask

    // Count the cycles in which the interrupt pulse stands
    task automatic watch(input int n, output int seen);
        seen = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (irq_pulse === 1'b1)
                seen++;
        end
    endtask

    // Move one source, then check its flag, read-clear and pulse
    task automatic step(input int i, input logic v, input logic masked);
        int seen;
        int want;
        logic fires;
        logic [3:0] addr;
        logic [7:0] got;
        fires = v || i == 0 || i == 6;
        want = (fires && !masked) ? `IRQ_PULSE_NS / `CLK_PERIOD_NS : 0;
        addr = (i < 7) ? `EVENT_FLAGS_ADDR : `FAULT_FLAGS_ADDR;
        set_src(i, v);
        watch(14, seen);
        host_u.reg_read(addr, got);
        `CHK("flags", fires ? bit_tab[i] : 8'h00, got)
        host_u.reg_read(addr, got);
        `CHK("flags after read", 8'h00, got)
        `CHK("irq cycles", want, seen)
    endtask

    // Closing report and verdict
    task automatic summarize;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #100000;
        num_errors++;
        summarize();
    end

    // Main test sequence
    initial begin
        int seen;
        logic sr;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 9; a <= 12; a++) begin
            host_u.reg_read(a[3:0], d);
            `CHK("reset value", 8'h00, d)
        end
        host_u.reg_read(4'h3, d);
        `CHK("unmapped", 8'h00, d)
        $display("test reset_values done");
        host_u.reg_write(`EVENT_MASK_ADDR, 8'hff);
        host_u.reg_write(`FAULT_MASK_ADDR, 8'hff);
        host_u.reg_read(`EVENT_MASK_ADDR, d);
        `CHK("event mask", 8'hfd, d)
        host_u.reg_read(`FAULT_MASK_ADDR, d);
        `CHK("fault mask", 8'hfe, d)
        for (int m = 1; m >= 0; m--) begin
            for (int i = 0; i < 14; i++) begin
                step(i, 1'b1, m[0]);
                step(i, 1'b0, m[0]);
            end
            host_u.reg_write(`EVENT_MASK_ADDR, 8'h00);
            host_u.reg_write(`FAULT_MASK_ADDR, 8'h00);
            host_u.reg_read(`FAULT_MASK_ADDR, d);
            `CHK("mask cleared", 8'h00, d)
            $display("test sources done");
        end
        host_u.reg_write(`EVENT_MASK_ADDR, 8'h04);
        set_src(4, 1'b1);
        watch(14, seen);
        host_u.reg_read(`EVENT_FLAGS_ADDR, d);
        `CHK("watchdog flag", 8'h08, d)
        set_src(7, 1'b1);
        watch(14, seen);
        host_u.reg_read(`FAULT_FLAGS_ADDR, d);
        `CHK("held fault", 8'h00, d)
        `CHK("held irq", 0, seen)
        host_u.reg_read(`EVENT_MASK_ADDR, d);
        `CHK("mask kept", 8'h04, d)
        set_src(7, 1'b0);
        set_src(4, 1'b0);
        watch(14, seen);
        host_u.reg_read(`FAULT_FLAGS_ADDR, d);
        host_u.reg_read(`EVENT_FLAGS_ADDR, d);
        $display("test watchdog_hold done");
        set_src(1, 1'b1);
        watch(14, seen);
        host_u.reg_write(`PRESET_ADDR, 8'h80);
        seen = 0;
        sr = 1'b0;
        repeat (3) begin
            #1;
            if (preset_pulse === 1'b1)
                seen++;
            sr = sr | timer_restart;
            @(posedge clk);
        end
        `CHK("preset pulse", 1, seen)
        `CHK("timer restart", 1'b1, sr)
        host_u.reg_read(`EVENT_MASK_ADDR, d);
        `CHK("mask after preset", 8'h00, d)
        host_u.reg_read(`EVENT_FLAGS_ADDR, d);
        `CHK("flags after preset", 8'h00, d)
        host_u.reg_read(`PRESET_ADDR, d);
        `CHK("preset self-clear", 8'h00, d)
        $display("test preset done");
        summarize();
    end
endmodule
`default_nettype wire
